// ===== inc/psb_pkg.sv
// shared constants and types for the pipelined burst sram bus control
package psb_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int PSB_LANES = 4;
  localparam int PSB_LANE_W = 9;
  localparam int PSB_ADDR_W = 19;

  // ****************************************
  // reset values and timing counts
  // ****************************************
  localparam logic [1:0] PSB_LO_RST = 2'h0;
  localparam logic [1:0] PSB_CNT_RST = 2'h0;
  localparam logic [1:0] PSB_CNT_STEP = 2'h1;
  // sleep entry and exit each take this many clock cycles
  localparam logic [1:0] PSB_SLEEP_CYC = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PSB_OP_NONE, PSB_OP_READ, PSB_OP_WRITE} psb_op_e;
  typedef enum logic [1:0] {PSB_SL_AWAKE, PSB_SL_ENTER, PSB_SL_ASLEEP, PSB_SL_EXIT} psb_sleep_e;

endpackage

// ===== inc/psb_burst_if.sv
// link between the cycle decoder and the burst address counter
`timescale 1ns/1ps
`default_nettype none
interface psb_burst_if;
  logic load;
  logic advance;
  logic mode;
  logic [1:0] load_lo;
  logic [1:0] next_lo;
  modport ctl (output load, output advance, output mode, output load_lo, input next_lo);
  modport ctr (input load, input advance, input mode, input load_lo, output next_lo);
endinterface
`default_nettype wire

// ===== hdl/psb_burst_ctr.sv
// two-bit burst address counter, linear or interleaved, wrapping
`timescale 1ns/1ps
`default_nettype none
module psb_burst_ctr
  import psb_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  psb_burst_if.ctr bif
);

  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic mode_r;
  wire [1:0] cnt_inc;

  assign cnt_inc = cnt_r + PSB_CNT_STEP;
  // interleaved order flips bits of the start, linear order adds and wraps
  assign bif.next_lo = mode_r ? (start_r ^ cnt_inc) : (start_r + cnt_inc);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_r <= PSB_LO_RST;
      cnt_r <= PSB_CNT_RST;
      mode_r <= 1'b0;
    end
    else if (clk_en && bif.load)
    begin
      start_r <= bif.load_lo;
      cnt_r <= PSB_CNT_RST;
      mode_r <= bif.mode;
    end
    else if (clk_en && bif.advance)
    begin
      cnt_r <= cnt_inc;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/psb_sram_bus.sv
// bus-side cycle control of a pipelined burst sram with common data i/o
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - chip is selected only when all three chip selects are active together
// - load with selects active and write strobe high starts a read burst at external address
// - advance during a read burst reads next burst address, selects and write strobe ignored
// - read with output enable off is a dummy read; address consumed, pins undriven
// - advance in a dummy read steps the address, pins stay undriven
// - load with write strobe low and a byte select active starts a write burst
// - each advance in a write burst writes next address using the byte selects given
// - load write with no byte selects aborts; nothing written, pins undriven
// - advance write with no byte selects steps address, writes nothing
// - clock qualifier high makes the edge ignored; pipeline state holds, but core read and write pulses end
// - any write cycle keeps all data and parity pins undriven
// - output enable is unregistered and masked during writes
// - read data driven only with output enable active and device selected
// - after reset device is deselected with pins undriven
// - each nine-bit lane has its own active-low write select
// - deselect is pipelined; drivers turn off after the following edge
// - write data is taken two edges after its address
// - burst counter walks the two low address bits, linear or interleaved, wrapping
// - sleep overrides all inputs, undrives pins, two cycles to enter and leave
module psb_sram_bus
  import psb_pkg::*;
#(
  parameter int LANES = PSB_LANES,
  parameter int ADDR_W = PSB_ADDR_W
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic clock_gate_n,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic advance_not_load,
  input wire logic write_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic burst_order,
  input wire logic out_en_n,
  input wire logic sleep_request,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES*PSB_LANE_W-1:0] dq_in,
  output logic [LANES*PSB_LANE_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic core_rd,
  output logic [ADDR_W-1:0] core_raddr,
  input wire logic [LANES*PSB_LANE_W-1:0] core_rdata,
  output logic core_wr,
  output logic [ADDR_W-1:0] core_waddr,
  output logic [LANES-1:0] core_wbe,
  output logic [LANES*PSB_LANE_W-1:0] core_wdata,
  output logic sleep_active
);

  // ****************************************
  // sleep input synchroniser and sequencer
  // ****************************************
  logic sleep_s1_r;
  logic sleep_s2_r;
  psb_sleep_e sl_r;
  psb_sleep_e sl_nxt;
  logic [1:0] sl_cnt_r;
  logic [1:0] sl_cnt_nxt;
  logic sleep_active_r;
  wire sl_done;

  assign sl_done = (sl_cnt_r == PSB_SLEEP_CYC - 2'h1);

  always_comb
  begin
    sl_nxt = sl_r;
    sl_cnt_nxt = PSB_CNT_RST;
    unique case (sl_r)
      PSB_SL_AWAKE:
        if (sleep_s2_r)
          sl_nxt = PSB_SL_ENTER;
      PSB_SL_ENTER:
      begin
        sl_cnt_nxt = sl_cnt_r + PSB_CNT_STEP;
        if (sl_done)
          sl_nxt = PSB_SL_ASLEEP;
      end
      PSB_SL_ASLEEP:
        if (!sleep_s2_r)
          sl_nxt = PSB_SL_EXIT;
      PSB_SL_EXIT:
      begin
        sl_cnt_nxt = sl_cnt_r + PSB_CNT_STEP;
        if (sl_done)
          sl_nxt = PSB_SL_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      sl_r <= PSB_SL_AWAKE;
      sl_cnt_r <= PSB_CNT_RST;
      sleep_active_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sleep_s1_r <= sleep_request;
      sleep_s2_r <= sleep_s1_r;
      sl_r <= sl_nxt;
      sl_cnt_r <= sl_cnt_nxt;
      sleep_active_r <= (sl_nxt == PSB_SL_ASLEEP);
    end
  end

  // ****************************************
  // cycle decode
  // ****************************************
  logic burst_act_r;
  logic burst_wr_r;
  logic [ADDR_W-1:0] base_r;
  psb_burst_if bif ();

  wire awake;
  wire run;
  wire flush;
  wire sel;
  wire any_be;
  wire load_cyc;
  wire start_rd;
  wire start_wr;
  wire adv_cyc;
  wire [ADDR_W-1:0] next_addr;
  wire [ADDR_W-1:0] cyc_addr;
  psb_op_e cyc_op;

  // sleep overrides every bus input and empties the pipeline
  assign awake = (sl_r == PSB_SL_AWAKE) && !sleep_s2_r;
  assign run = clk_en && !clock_gate_n && awake;
  assign flush = clk_en && !awake;
  assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  assign any_be = !(&byte_lane_write_n);
  assign load_cyc = !advance_not_load;
  assign start_rd = load_cyc && sel && write_n;
  assign start_wr = load_cyc && sel && !write_n;
  // selects and write strobe are not looked at while advancing
  assign adv_cyc = advance_not_load && burst_act_r;
  assign next_addr = {base_r[ADDR_W-1:2], bif.next_lo};
  assign cyc_addr = load_cyc ? addr_in : next_addr;
  assign cyc_op = start_rd ? PSB_OP_READ :
                  start_wr ? PSB_OP_WRITE :
                  (adv_cyc && burst_wr_r) ? PSB_OP_WRITE :
                  adv_cyc ? PSB_OP_READ : PSB_OP_NONE;

  assign bif.load = run && load_cyc && sel;
  assign bif.advance = run && adv_cyc;
  assign bif.mode = burst_order;
  assign bif.load_lo = addr_in[1:0];

  psb_burst_ctr u_ctr (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .bif(bif)
  );

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      burst_act_r <= 1'b0;
      burst_wr_r <= 1'b0;
      base_r <= '0;
    end
    else if (flush)
    begin
      burst_act_r <= 1'b0;
    end
    else if (run && load_cyc)
    begin
      burst_act_r <= sel;
      burst_wr_r <= !write_n;
      base_r <= addr_in;
    end
  end

  // ****************************************
  // access pipeline
  // ****************************************
  logic core_rd_r;
  logic [ADDR_W-1:0] core_raddr_r;
  logic s1_rd_r;
  logic s1_wr_r;
  logic [ADDR_W-1:0] s1_waddr_r;
  logic [LANES-1:0] s1_be_r;
  logic s2_wr_r;
  logic [ADDR_W-1:0] s2_waddr_r;
  logic [LANES-1:0] s2_be_r;
  logic core_wr_r;
  logic [ADDR_W-1:0] core_waddr_r;
  logic [LANES-1:0] core_wbe_r;
  logic [LANES*PSB_LANE_W-1:0] core_wdata_r;
  logic [LANES*PSB_LANE_W-1:0] dq_out_r;
  logic drive_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_rd_r <= 1'b0;
      core_raddr_r <= '0;
      s1_rd_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_waddr_r <= '0;
      s1_be_r <= '0;
      s2_wr_r <= 1'b0;
      s2_waddr_r <= '0;
      s2_be_r <= '0;
      core_wr_r <= 1'b0;
      core_waddr_r <= '0;
      core_wbe_r <= '0;
      core_wdata_r <= '0;
      drive_r <= 1'b0;
    end
    else if (flush)
    begin
      core_rd_r <= 1'b0;
      s1_rd_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s2_wr_r <= 1'b0;
      core_wr_r <= 1'b0;
      drive_r <= 1'b0;
    end
    else if (run)
    begin
      // dummy reads still consume the address; only the pins stay off
      core_rd_r <= (cyc_op == PSB_OP_READ);
      core_raddr_r <= cyc_addr;
      s1_rd_r <= (cyc_op == PSB_OP_READ);
      // a write with no byte selects moves the address and writes nothing
      s1_wr_r <= (cyc_op == PSB_OP_WRITE) && any_be;
      s1_waddr_r <= cyc_addr;
      s1_be_r <= ~byte_lane_write_n;
      s2_wr_r <= s1_wr_r;
      s2_waddr_r <= s1_waddr_r;
      s2_be_r <= s1_be_r;
      core_wr_r <= s2_wr_r;
      core_waddr_r <= s2_waddr_r;
      core_wbe_r <= s2_be_r;
      core_wdata_r <= dq_in;
      // deselect or write turns drivers off one edge after it is taken
      drive_r <= s1_rd_r;
    end
    else if (clk_en)
    begin
      // stalled edge: pulses end, everything else holds
      core_rd_r <= 1'b0;
      core_wr_r <= 1'b0;
    end
  end

  // read data is caught on the edge after issue even if that edge stalls
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      dq_out_r <= '0;
    else if (clk_en && core_rd_r)
      dq_out_r <= core_rdata;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dq_out = dq_out_r;
  // output enable acts without the clock; drive_r masks it in writes,
  // deselects and sleep, so it can never turn drivers on there
  assign dq_oe_n = !(drive_r && !out_en_n);
  assign core_rd = core_rd_r;
  assign core_raddr = core_raddr_r;
  assign core_wr = core_wr_r;
  assign core_waddr = core_waddr_r;
  assign core_wbe = core_wbe_r;
  assign core_wdata = core_wdata_r;
  assign sleep_active = sleep_active_r;

endmodule
`default_nettype wire

// ===== verif/psb_array_model.sv
// behavioural array model on the core side of the bus control
`timescale 1ns/1ps
`default_nettype none
module psb_array_model
  import psb_pkg::*;
(
  input wire logic clock,
  input wire logic core_rd,
  input wire logic [PSB_ADDR_W-1:0] core_raddr,
  output logic [PSB_LANES*PSB_LANE_W-1:0] core_rdata,
  input wire logic core_wr,
  input wire logic [PSB_ADDR_W-1:0] core_waddr,
  input wire logic [PSB_LANES-1:0] core_wbe,
  input wire logic [PSB_LANES*PSB_LANE_W-1:0] core_wdata
);
  logic [PSB_LANES*PSB_LANE_W-1:0] mem [16] = '{default: '0};
  // outside a read the lines carry the inverse, so stale data never looks valid
  assign core_rdata = core_rd ? mem[core_raddr[3:0]] : ~mem[core_raddr[3:0]];
  always @(posedge clock)
    for (int i = 0; i < PSB_LANES; i++)
      if (core_wr && core_wbe[i])
        mem[core_waddr[3:0]][i*PSB_LANE_W+:PSB_LANE_W] <=
          core_wdata[i*PSB_LANE_W+:PSB_LANE_W];
endmodule
`default_nettype wire

// ===== verif/psb_sram_bus_properties.sv
// concurrent checks on the ports of the burst sram bus control
`timescale 1ns/1ps
`default_nettype none
module psb_sram_bus_properties
  import psb_pkg::*;
#(
  parameter int LANES = PSB_LANES,
  parameter int ADDR_W = PSB_ADDR_W
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic clock_gate_n,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic advance_not_load,
  input wire logic write_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic burst_order,
  input wire logic out_en_n,
  input wire logic sleep_request,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES*PSB_LANE_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic core_rd,
  input wire logic [ADDR_W-1:0] core_raddr,
  input wire logic [LANES*PSB_LANE_W-1:0] core_rdata,
  input wire logic core_wr,
  input wire logic [ADDR_W-1:0] core_waddr,
  input wire logic [LANES-1:0] core_wbe,
  input wire logic sleep_active
);
  logic [2:0] quiet_r;
  logic [1:0] lo;
  logic sel, taken, rd_ld, wr_ld;
  assign lo = addr_in[1:0];
  assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  // only count edges once sleep has been low long enough for wake-up to finish
  assign taken = clk_en && !clock_gate_n && quiet_r == 3'h7;
  assign rd_ld = taken && sel && !advance_not_load && write_n;
  assign wr_ld = taken && sel && !advance_not_load && !write_n;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      quiet_r <= 3'h0;
    else if (sleep_request)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  oe_gate_a: assert property (out_en_n |-> dq_oe_n) else $error("drive without enable");
  rd_issue_a: assert property (rd_ld |=> core_rd && core_raddr == $past(addr_in))
    else $error("read not issued");
  burst_step_a: assert property (rd_ld ##1 (taken && advance_not_load) |=> core_rd &&
    core_raddr[1:0] == ($past(burst_order, 2) ? $past(lo, 2) ^ 2'h1 : $past(lo, 2) + 2'h1))
    else $error("burst step wrong");
  rd_data_a: assert property (rd_ld ##1 taken |=>
    dq_out == $past(core_rdata) && dq_oe_n == out_en_n) else $error("read data wrong");
  wr_commit_a: assert property ((wr_ld && !(&byte_lane_write_n)) ##1 taken ##1 taken |=>
    core_wr && core_waddr == $past(addr_in, 3) && core_wbe == ~$past(byte_lane_write_n, 3))
    else $error("write not committed");
  wr_abort_a: assert property ((wr_ld && &byte_lane_write_n) ##1 taken ##1 taken |=>
    !core_wr) else $error("aborted write committed");
  desel_off_a: assert property ((taken && !sel && !advance_not_load) ##1 taken |=>
    dq_oe_n) else $error("drive after deselect");
  sleep_off_a: assert property (sleep_active |-> dq_oe_n && !core_rd && !core_wr)
    else $error("activity in sleep");
  cover property (rd_ld ##1 (taken && advance_not_load));
  cover property (wr_ld ##3 core_wr);
  cover property (sleep_active);
endmodule
bind psb_sram_bus psb_sram_bus_properties #(.LANES(LANES), .ADDR_W(ADDR_W))
  psb_sram_bus_properties_i (
  .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .clock_gate_n(clock_gate_n),
  .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n),
  .advance_not_load(advance_not_load), .write_n(write_n), .byte_lane_write_n(byte_lane_write_n),
  .burst_order(burst_order), .out_en_n(out_en_n), .sleep_request(sleep_request),
  .addr_in(addr_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .core_rd(core_rd),
  .core_raddr(core_raddr), .core_rdata(core_rdata), .core_wr(core_wr),
  .core_waddr(core_waddr), .core_wbe(core_wbe), .sleep_active(sleep_active));
`default_nettype wire

// ===== verif/tb_psb_sram_bus.sv
// self-checking bench for the burst sram bus control
`timescale 1ns/1ps
`default_nettype none
module tb_psb_sram_bus;
  import psb_pkg::*;
  localparam int DW = PSB_LANES * PSB_LANE_W;
  localparam int CW = PSB_ADDR_W + PSB_LANES + DW;
  logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, clock_gate_n = 1'b0;
  logic chip_sel1_n = 1'b1, chip_sel2 = 1'b0, chip_sel3_n = 1'b1;
  logic advance_not_load = 1'b0, write_n = 1'b1, burst_order = 1'b0;
  logic out_en_n = 1'b1, sleep_request = 1'b0;
  logic [PSB_LANES-1:0] byte_lane_write_n = 4'hf;
  logic [PSB_ADDR_W-1:0] addr_in = '0;
  logic [DW-1:0] dq_in = '0;
  logic [DW-1:0] dq_out, core_rdata, core_wdata;
  logic dq_oe_n, core_rd, core_wr, sleep_active;
  logic [PSB_ADDR_W-1:0] core_raddr, core_waddr;
  logic [PSB_LANES-1:0] core_wbe;
  logic [31:0] seed = 32'hba27;
  logic [DW-1:0] dsh [2] = '{default: '0};
  logic [DW-1:0] shadow [16] = '{default: '0};
  logic [DW:0] rp [2] = '{default: '0};
  logic [CW-1:0] wq [$];
  logic [CW-1:0] rq [$];
  logic inb = 1'b0, bt = 1'b0, ord = 1'b0, oe = 1'b1, gn = 1'b0;
  logic ce = 1'b1, en_q = 1'b1;
  logic [3:0] st = '0, ea;
  logic [1:0] k = '0;
  int n_errors = 0, comparisons = 0, cyc = 0;
  psb_sram_bus psb_sram_bus_i (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .clock_gate_n(clock_gate_n),
    .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n),
    .advance_not_load(advance_not_load), .write_n(write_n), .byte_lane_write_n(byte_lane_write_n),
    .burst_order(burst_order), .out_en_n(out_en_n), .sleep_request(sleep_request),
    .addr_in(addr_in), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .core_rd(core_rd),
    .core_raddr(core_raddr), .core_rdata(core_rdata), .core_wr(core_wr),
    .core_waddr(core_waddr), .core_wbe(core_wbe), .core_wdata(core_wdata),
    .sleep_active(sleep_active));
  psb_array_model psb_array_model_i (
    .clock(clock), .core_rd(core_rd), .core_raddr(core_raddr), .core_rdata(core_rdata),
    .core_wr(core_wr), .core_waddr(core_waddr), .core_wbe(core_wbe), .core_wdata(core_wdata));
  initial forever #5 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // s picks the select left inactive, 0 selects the device
  task op(input logic adv, input logic [1:0] s, input logic wr, input logic [3:0] bw,
          input logic [3:0] a, input logic o);
    logic [DW-1:0] d;
    @(posedge clock);
    seed = lfsr(seed);
    d = {seed[3:0], seed};
    advance_not_load <= adv;
    chip_sel1_n <= (s == 2'h1);
    chip_sel2 <= (s != 2'h2);
    chip_sel3_n <= (s == 2'h3);
    write_n <= wr;
    byte_lane_write_n <= bw;
    addr_in <= PSB_ADDR_W'(a);
    burst_order <= o;
    out_en_n <= oe;
    clock_gate_n <= gn;
    clk_en <= ce;
    // read data shows two calls later, so it is judged by that call's enable
    if (!oe && rp[1][DW])
      rq.push_back(CW'(rp[1][DW-1:0]));
    rp[1] = rp[0];
    rp[0] = '0;
    // a stalled or frozen edge takes nothing, so the model does not move either
    if (!gn && ce)
    begin
      dq_in <= dsh[1];
      dsh[1] = dsh[0];
      dsh[0] = d;
      if (!adv)
      begin
        inb = (s == 2'h0);
        bt = wr;
        st = a;
        ord = o;
        k = 2'h0;
      end
      else
        k = k + 2'h1;
      ea = {st[3:2], ord ? st[1:0] ^ k : st[1:0] + k};
      if (inb && !bt && bw != 4'hf)
      begin
        wq.push_back({PSB_ADDR_W'(ea), ~bw, d});
        for (int i = 0; i < PSB_LANES; i++)
          if (!bw[i])
            shadow[ea][i*PSB_LANE_W+:PSB_LANE_W] = d[i*PSB_LANE_W+:PSB_LANE_W];
      end
      if (inb && bt)
        rp[0] = {1'b1, shadow[ea]};
    end
  endtask
  task idle(input int n);
    for (int i = 0; i < n; i++)
      op(1'b0, 2'(i % 3 + 1), 1'b1, 4'hf, 4'h0, 1'b0);
  endtask
  always @(posedge clock)
  begin
    // after a frozen edge the outputs repeat the cycle already judged
    if (rst_b && en_q && core_wr === 1'b1)
      check({core_waddr, core_wbe, core_wdata}, wq.size() ? wq.pop_front() : 'x);
    if (rst_b && en_q && dq_oe_n === 1'b0)
      check(CW'(dq_out), rq.size() ? rq.pop_front() : 'x);
    en_q = clk_en;
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    idle(6);
    op(1'b0, 2'h0, 1'b0, 4'h0, 4'h4, 1'b0);
    op(1'b1, 2'h0, 1'b0, 4'hf, 4'h4, 1'b0);
    // a frozen edge inside the burst must neither write nor step the address
    ce = 1'b0;
    op(1'b1, 2'h0, 1'b0, 4'h0, 4'h4, 1'b0);
    ce = 1'b1;
    repeat (2) op(1'b1, 2'h0, 1'b0, seed[3:0], 4'h4, 1'b0);
    op(1'b0, 2'h0, 1'b0, 4'h5, 4'ha, 1'b1);
    repeat (4) op(1'b1, 2'h0, 1'b0, seed[7:4], 4'ha, 1'b0);
    op(1'b0, 2'h0, 1'b0, 4'hf, 4'hc, 1'b0);
    op(1'b1, 2'h0, 1'b0, 4'h3, 4'hc, 1'b0);
    idle(6);
    oe = 1'b0;
    op(1'b0, 2'h0, 1'b1, 4'h0, 4'h4, 1'b0);
    repeat (3) op(1'b1, 2'h1, 1'b0, 4'h0, 4'h4, 1'b0);
    op(1'b0, 2'h0, 1'b1, 4'h0, 4'ha, 1'b1);
    repeat (4) op(1'b1, 2'h0, 1'b1, 4'h0, 4'ha, 1'b0);
    oe = 1'b1;
    op(1'b0, 2'h0, 1'b1, 4'h0, 4'hc, 1'b0);
    gn = 1'b1;
    op(1'b1, 2'h0, 1'b1, 4'h0, 4'hc, 1'b0);
    gn = 1'b0;
    repeat (2) op(1'b1, 2'h0, 1'b1, 4'h0, 4'hc, 1'b0);
    oe = 1'b0;
    op(1'b0, 2'h0, 1'b1, 4'h0, 4'hd, 1'b0);
    op(1'b0, 2'h0, 1'b0, 4'h0, 4'he, 1'b0);
    idle(6);
    sleep_request <= 1'b1;
    idle(8);
    check(CW'(sleep_active), CW'(1));
    sleep_request <= 1'b0;
    idle(8);
    check(CW'(sleep_active), CW'(0));
    check(CW'(wq.size() + rq.size()), CW'(0));
    wrap_up();
  end
endmodule
`default_nettype wire
